//--- design/csg_addr_gen.sv
`include "csg_defines.svh"
module csg_addr_gen
  import csg_pkg::*;
(
  // Operand fields
  input wire logic [7:0] file_addr,
  input wire logic access_bit,
  // Core context
  input wire logic [3:0] bank_select_register,
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  // Resolved address
  output csg_mem_req_t req
);
  wire logic use_idx;
  wire logic [11:0] idx_addr;
  wire logic [11:0] acc_addr;
  wire logic [11:0] bank_addr;
  assign use_idx = !access_bit && ext_set_en && (file_addr <= `CSG_IDX_LIMIT); // [RQ5]
  assign idx_addr = 12'(index_base + {4'h0, file_addr});
  assign acc_addr = (file_addr < `CSG_ACC_SPLIT) ? {4'h0, file_addr}
                                                : {`CSG_ACC_HI_BANK, file_addr}; // [RQ4]
  assign bank_addr = {bank_select_register, file_addr}; // [RQ4]
  assign req.addr = use_idx ? idx_addr : (access_bit ? bank_addr : acc_addr);
  assign req.indexed = use_idx;
endmodule : csg_addr_gen

//--- design/csg_core.sv
// Behaviour
// [RQ1] Unsigned subtract memory byte minus working register; skip only if strictly greater.
// [RQ2] Decode opcode 0110 010a; low byte is file address, bit 8 is access bit.
// [RQ3] On success discard fetched instruction and run a no-operation in its place.
// [RQ4] Access bit 0 selects access bank; 1 uses bank select register bank.
// [RQ5] Access bit 0 with extended set uses indexed literal offset for f up to 5Fh.
// [RQ6] One word; one cycle, two with skip, three if skipped instruction is two words.
// [RQ7] Status flags untouched; subtraction result never written back anywhere.
`include "csg_defines.svh"
module csg_core
  import csg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Instruction stream, one word per instruction cycle
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic next_is_two_word,
  // Core context
  input wire logic [7:0] working_register_alias,
  input wire logic [3:0] bank_select_register,
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  // Data memory read
  output logic [11:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  // Results
  output logic [1:0] q_phase,
  output logic cycle_end,
  output logic is_compare,
  output logic skip_active,
  output logic flush_fetch,
  output logic instr_done,
  output logic status_we,
  output logic result_we
);
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SKIP1, ST_SKIP2} csg_state_t;

  csg_state_t state_r, state_nxt;
  logic [1:0] q_r;
  logic [11:0] addr_r;
  logic rd_r, done_r, flush_r, cmp_r, skip_r;
  logic two_word_r;
  // Output flops; every port of the block leaves straight from a register.
  logic cycle_end_r, status_we_r, result_we_r;
  csg_mem_req_t req;
  csg_operands_t ops;

  function automatic logic f_greater(input logic [7:0] f, input logic [7:0] w);
    logic [8:0] diff;
    diff = {1'b0, f} - {1'b0, w};
    // No borrow and non-zero difference means f is strictly greater.
    return !diff[8] && (diff[7:0] != 8'h00); // [RQ1]
  endfunction : f_greater

  wire logic q_last = (q_r == 2'(`CSG_Q_PHASES - 1));
  wire logic q_first = (q_r == 2'h0);
  wire logic opc_hit = instr_valid &&
      (instr_word[`CSG_OPC_HI:`CSG_OPC_LO] == `CSG_OPC_VAL); // [RQ2]
  wire logic [7:0] file_addr = instr_word[`CSG_FILE_HI:0]; // [RQ2]
  wire logic access_bit = instr_word[`CSG_ABIT]; // [RQ2]
  assign ops.fdata = mem_rdata;
  assign ops.wdata = working_register_alias;
  wire logic greater = f_greater(ops.fdata, ops.wdata);
  // A word is taken only in Q1 of a free cycle; words offered while busy are dropped.
  wire logic decode_take = (state_r == ST_IDLE) && q_first && opc_hit; // [RQ2]
  wire logic process_phase = (state_r == ST_EXEC) && (q_r == 2'h2); // [RQ1]

  // The two-bit phase counter wraps by itself, so exactly four phases are served.
  if (`CSG_Q_PHASES != 4) begin : g_phase_check
    $error("csg_core serves exactly four phases per instruction cycle");
  end

  csg_addr_gen u_addr (
    .file_addr(file_addr),
    .access_bit(access_bit),
    .bank_select_register(bank_select_register),
    .ext_set_en(ext_set_en),
    .index_base(index_base),
    .req(req)
  );

  // Q1 decodes; Q2 reads; Q3 compares; Q4 retires or starts the skip.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (q_first && opc_hit) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (q_last) begin
          state_nxt = skip_r ? ST_SKIP1 : ST_IDLE; // [RQ6]
        end
      end
      ST_SKIP1: begin
        if (q_last) begin
          state_nxt = two_word_r ? ST_SKIP2 : ST_IDLE; // [RQ6]
        end
      end
      ST_SKIP2: begin
        if (q_last) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State moves only on the Q4 edge of each cycle, apart from the decode in Q1.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The phase counter never stops, so decode lines up with Q1 for any instruction.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q_r <= 2'h0;
    end else begin
      q_r <= 2'(q_r + 2'h1);
    end
  end

  // Registered so that the phase strobe leaves the block free of decode glitches.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cycle_end_r <= 1'b1;
    end else begin
      cycle_end_r <= q_last;
    end
  end

  // Address is latched at decode so a changing instruction bus cannot move it.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_r <= 12'h000;
    end else if (decode_take) begin
      addr_r <= req.addr; // [RQ4] [RQ5]
    end
  end

  // The read strobe is set on the decode edge so that it stands through Q2 only.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_r <= 1'b0;
    end else begin
      rd_r <= decode_take; // [RQ2]
    end
  end

  // Compare flag mirrors the execute state for the three phases after decode.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmp_r <= 1'b0;
    end else begin
      cmp_r <= state_nxt == ST_EXEC;
    end
  end

  // The skip decision only; the difference is discarded and no flag moves.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      skip_r <= 1'b0;
    end else if (process_phase) begin
      skip_r <= greater; // [RQ1] [RQ7]
    end else if (state_r == ST_IDLE) begin
      skip_r <= 1'b0;
    end
  end

  // Sampled with the operands, as the length of the following word is known by Q3.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      two_word_r <= 1'b0;
    end else if (process_phase) begin
      two_word_r <= next_is_two_word; // [RQ6]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flush_r <= 1'b0;
    end else begin
      flush_r <= (state_nxt == ST_SKIP1) || (state_nxt == ST_SKIP2); // [RQ3]
    end
  end

  // Retirement is flagged for one clock in the Q1 that follows the last cycle.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE); // [RQ6]
    end
  end

  // The compare owns no write port; these strobes stay low so that no flag or file moves.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_we_r <= 1'b0;
      result_we_r <= 1'b0;
    end else begin
      status_we_r <= 1'b0; // [RQ7]
      result_we_r <= 1'b0; // [RQ7]
    end
  end

  assign mem_addr = addr_r;
  assign mem_rd = rd_r;
  assign q_phase = q_r;
  assign cycle_end = cycle_end_r;
  assign is_compare = cmp_r;
  assign skip_active = flush_r;
  assign flush_fetch = flush_r; // [RQ3]
  assign instr_done = done_r;
  assign status_we = status_we_r; // [RQ7]
  assign result_we = result_we_r; // [RQ7]
endmodule : csg_core

//--- design/csg_defines.svh
`ifndef CSG_DEFINES_SVH
`define CSG_DEFINES_SVH
// Opcode field: bits 15:9 must match 0110 010.
`define CSG_OPC_HI 15
`define CSG_OPC_LO 9
`define CSG_OPC_VAL 7'h32
`define CSG_ABIT 8
`define CSG_FILE_HI 7
// Indexed literal offset limit, inclusive.
`define CSG_IDX_LIMIT 8'h5F
// Access bank: low half maps to bank 0, the rest to the top bank.
`define CSG_ACC_SPLIT 8'h80
`define CSG_ACC_HI_BANK 4'hF
// Q phases per instruction cycle.
`define CSG_Q_PHASES 4
`endif

//--- design/csg_pkg.sv
package csg_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic indexed;
  } csg_mem_req_t;
  typedef struct packed {
    logic [7:0] fdata;
    logic [7:0] wdata;
  } csg_operands_t;
endpackage : csg_pkg

//--- verification/csg_core_assertions.sv
module csg_core_chk
  import csg_pkg::*;
(
  // Watched ports
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic next_is_two_word,
  input wire logic [7:0] working_register_alias,
  input wire logic [3:0] bank_select_register,
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic [1:0] q_phase,
  input wire logic is_compare,
  input wire logic skip_active,
  input wire logic flush_fetch,
  input wire logic instr_done,
  input wire logic status_we,
  input wire logic result_we
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  wire idle = q_phase == 2'h0 && instr_valid && !is_compare && !skip_active;
  wire hit = instr_word[15:9] == 7'h32;
  wire [7:0] f = instr_word[7:0];
  wire idx = !instr_word[8] && ext_set_en && f <= 8'h5F;
  wire gt = mem_rdata > working_register_alias;
  wire [11:0] ea = instr_word[8] ? {bank_select_register, f} :
    idx ? index_base + f : {f[7] ? 4'hF : 4'h0, f};
  sequence s_nop4;
    flush_fetch [*4];
  endsequence
  a_opcode_taken: assert property (idle && hit |=> is_compare && mem_rd)
    else $error("compare word not taken");
  a_other_refused: assert property (idle && !hit |=> !is_compare)
    else $error("foreign word taken");
  a_bank_addr: assert property (idle && hit && !idx |=> mem_addr == $past(ea))
    else $error("bank address wrong");
  a_indexed_addr: assert property (idle && hit && idx |=> mem_addr == $past(ea))
    else $error("indexed address wrong");
  a_skip_choice: assert property (is_compare && q_phase == 2'h2 |-> ##2
    flush_fetch == $past(gt, 2) && instr_done != $past(gt, 2))
    else $error("skip decision wrong");
  a_nop_length: assert property ($rose(flush_fetch) |-> s_nop4 ##1
    ($past(next_is_two_word, 6) ? flush_fetch : instr_done))
    else $error("no-op length wrong");
  a_long_skip: assert property ($rose(flush_fetch) && $past(next_is_two_word, 2) |->
    s_nop4 ##1 s_nop4 ##1 instr_done)
    else $error("two-word skip length wrong");
  a_read_phase: assert property (mem_rd |-> q_phase == 2'h1 && is_compare)
    else $error("read outside its phase");
  a_flags_kept: assert property (!status_we && !result_we)
    else $error("write-back seen");
endmodule : csg_core_chk

bind csg_core csg_core_chk chk (.*);

//--- verification/csg_core_test.sv
module csg_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, nrst, instr_valid, next_is_two_word, ext_set_en;
  logic [15:0] instr_word;
  logic [7:0] working_register_alias, mem_rdata;
  logic [3:0] bank_select_register;
  logic [11:0] index_base, mem_addr;
  logic [1:0] q_phase;
  logic mem_rd, cycle_end, is_compare, skip_active, flush_fetch, instr_done;
  logic status_we, result_we;
  int err_count = 0, check_count = 0, cyc = 0;
  csg_core uut (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  function automatic logic [11:0] exp_addr(input logic [15:0] wd);
    if (wd[8]) return {bank_select_register, wd[7:0]};
    if (ext_set_en && wd[7:0] <= 8'h5F) return index_base + wd[7:0];
    return {wd[7] ? 4'hF : 4'h0, wd[7:0]};
  endfunction : exp_addr
  task automatic run(input logic [15:0] wd, input logic [7:0] w, input logic [7:0] fv,
                     input logic two);
    int n;
    logic hit;
    hit = wd[15:9] == 7'h32;
    do @(negedge clk_sys); while (q_phase !== 2'h0);
    instr_word = wd;
    instr_valid = 1'b1;
    working_register_alias = w;
    mem_rdata = fv;
    next_is_two_word = two;
    @(negedge clk_sys);
    instr_valid = 1'b0;
    chk(12'(mem_rd), 12'(hit));
    chk(12'(is_compare), 12'(hit));
    chk(12'(q_phase), 12'h001);
    chk(12'(cycle_end), 12'h000);
    if (hit) begin
      chk(mem_addr, exp_addr(wd));
      repeat (3) @(negedge clk_sys);
      chk(12'(cycle_end), 12'h001);
      chk(12'(skip_active), 12'(fv > w));
      n = 0;
      while (flush_fetch === 1'b1 && n < 9) begin
        n++;
        @(negedge clk_sys);
      end
      chk(12'(n), fv > w ? (two ? 12'h008 : 12'h004) : 12'h000);
      chk(12'(instr_done), 12'h001);
      @(negedge clk_sys);
      chk(12'(instr_done), 12'h000);
    end
    chk(12'(status_we | result_we), 12'h000);
    $display("test %h done at %0t", wd, $time);
  endtask : run
  // The cycle ceiling is far above the at most about 740 cycles the tests need.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results;
    end
  end
  initial begin
    {nrst, instr_valid, next_is_two_word, ext_set_en, instr_word} = '0;
    {working_register_alias, mem_rdata, bank_select_register, index_base} = '0;
    void'($urandom(57980));
    repeat (20) @(negedge clk_sys);
    nrst = 1'b1;
    ext_set_en = 1'b1;
    run(16'h6010, 8'h55, 8'h55, 1'b0);
    run(16'h6410, 8'h55, 8'h55, 1'b0);
    run(16'h64A0, 8'h10, 8'h11, 1'b1);
    run(16'h645F, 8'h55, 8'h56, 1'b1);
    run(16'h6460, 8'hFF, 8'h00, 1'b0);
    run(16'h6590, 8'h00, 8'hFF, 1'b0);
    run(16'h6000, 8'h00, 8'hFF, 1'b0);
    run(16'h6210, 8'h00, 8'hFF, 1'b0);
    for (int i = 0; i < 40; i++) begin
      bank_select_register = 4'($urandom);
      ext_set_en = 1'($urandom);
      index_base = 12'($urandom);
      run({7'h32, 9'($urandom)}, 8'($urandom), 8'($urandom), 1'($urandom));
    end
    results;
  end
endmodule : csg_core_test
